// ---- logic/rss_pkg.sv ----
package rss_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hff;
  localparam logic [7:0] RESET_CAUSE_REGISTER_ADDR   = 8'hef;

  // Supply monitor control field positions
  localparam int SMC_MONITOR_ON_BIT   = 7;
  localparam int SMC_ABOVE_RST_BIT    = 6;
  localparam int SMC_ABOVE_WARN_BIT   = 5;
  localparam int SMC_BATT_WARN_BIT    = 4;
  localparam int SMC_CORE_IRQ_EN_BIT  = 3;
  localparam int SMC_BATT_IRQ_EN_BIT  = 2;

  // Reset cause register field positions
  localparam int RCR_RTC_BIT   = 7;
  localparam int RCR_FLASH_BIT = 6;
  localparam int RCR_CMP_BIT   = 5;
  localparam int RCR_SOFT_BIT  = 4;
  localparam int RCR_WDOG_BIT  = 3;
  localparam int RCR_CLOCK_BIT = 2;
  localparam int RCR_POWER_BIT = 1;
  localparam int RCR_PIN_BIT   = 0;

  // Values after reset
  localparam logic       SMC_MONITOR_ON_RST  = 1'b1;
  localparam logic       SMC_CORE_IRQ_EN_RST = 1'b1;
  localparam logic       SMC_BATT_IRQ_EN_RST = 1'b0;
  localparam logic [7:0] CAUSE_POWER_ON      = 8'h02;
  localparam logic [7:0] SYNC_RST_VALUE      = 8'h73;

  // Synchronised pin vector positions
  localparam int PIN_RST      = 0;
  localparam int PIN_CMP      = 1;
  localparam int PIN_ALARM    = 2;
  localparam int PIN_OSC_FAIL = 3;
  localparam int PIN_VDD_RST  = 4;
  localparam int PIN_VDD_WARN = 5;
  localparam int PIN_VBAT     = 6;
  localparam int PIN_CLK_ACT  = 7;

  // Timing
  localparam int CLK_HZ             = 20_000_000;
  localparam int CLK_LOSS_TIME_US   = 100;
  localparam int CLK_LOSS_CYCLES    = CLK_LOSS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_DIVIDE        = 12;
  localparam int WDOG_TICKS_DEFAULT = 256;
  localparam int HOLD_CYCLES        = 4;

  typedef enum logic {ST_RUN, ST_HOLD} rss_state_t;

endpackage

// ---- logic/rss_tmr_if.sv ----
`timescale 1ns/1ps
interface rss_tmr_if;
  logic run;
  logic kick;
  logic tick;
  logic expired;

  modport ctl (output run, output kick, output tick, input expired);
  modport tmr (input run, input kick, input tick, output expired);
endinterface

// ---- logic/rss_timer.sv ----
`timescale 1ns/1ps
module rss_timer #(
  parameter int LIMIT = 16
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // Control from the sequencer
  rss_tmr_if.tmr    t
);
  import rss_pkg::*;

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          expired;
  logic          next_expired;

  // Counts ticks while running; a kick or a stop restarts it
  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (!t.run || t.kick) begin
      next_count = '0;
    end else if (t.tick) begin
      if (count == LAST) begin
        next_count   = '0;
        next_expired = 1'b1;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

  assign t.expired = expired;

endmodule

// ---- logic/rss_sequencer.sv ----
`timescale 1ns/1ps
module rss_sequencer #(
  parameter int WDOG_TICKS = rss_pkg::WDOG_TICKS_DEFAULT
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // Special function register bus
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  output logic      [7:0] SFR_RDATA,
  // Reset pin, open drain
  input  wire logic       RST_PIN_I,
  output logic            RST_PIN_O,
  output logic            RST_PIN_OE,
  // Analog and clock status pins
  input  wire logic       CMP_OUT,
  input  wire logic       RTC_ALARM,
  input  wire logic       RTC_OSC_FAIL,
  input  wire logic       VDD_ABOVE_RST,
  input  wire logic       VDD_ABOVE_WARN,
  input  wire logic       VBAT_ABOVE_WARN,
  input  wire logic       CLK_ACTIVITY,
  // Same-domain control inputs
  input  wire logic       LOW_POWER,
  input  wire logic       CMP_WAKE_EN,
  input  wire logic       FLASH_FAULT,
  input  wire logic       WDOG_SERVICE,
  input  wire logic       WDOG_DISABLE,
  // System outputs
  output logic            SYS_RST_N,
  output logic            CORE_WARN_IRQ,
  output logic            BATT_WARN_IRQ
);
  import rss_pkg::*;

  localparam int HC_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [HC_W-1:0] HOLD_LAST = HC_W'(HOLD_CYCLES - 1);
  localparam int DV_W = $clog2(WDOG_DIVIDE + 1);
  localparam logic [DV_W-1:0] DIV_LAST = DV_W'(WDOG_DIVIDE - 1);

  // Pin synchronisers
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic       act_prev;

  // Sequencer state
  rss_state_t      state;
  rss_state_t      next_state;
  logic [HC_W-1:0] hold_cnt;
  logic [HC_W-1:0] next_hold_cnt;
  logic [7:0]      cause;
  logic [7:0]      next_cause;
  logic            drive_pin;
  logic            next_drive_pin;

  // Software settings
  logic monitor_on;
  logic next_monitor_on;
  logic supply_sel;
  logic next_supply_sel;
  logic core_irq_en;
  logic next_core_irq_en;
  logic batt_irq_en;
  logic next_batt_irq_en;
  logic clock_loss_en;
  logic next_clock_loss_en;
  logic cmp_en;
  logic next_cmp_en;
  logic rtc_en;
  logic next_rtc_en;
  logic wdog_en;
  logic next_wdog_en;
  logic [DV_W-1:0] div_cnt;
  logic [DV_W-1:0] next_div_cnt;

  // Output registers
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic       core_irq;
  logic       batt_irq;

  // Decoded events
  logic       running;
  logic       wr_smc;
  logic       wr_rcr;
  logic       pin_req;
  logic       supply_req;
  logic       clock_req;
  logic       cmp_req;
  logic       wdog_req;
  logic       flash_req;
  logic       rtc_req;
  logic       soft_req;
  logic [7:0] req_cause;

  rss_tmr_if clk_tmr ();
  rss_tmr_if wdg_tmr ();

  // Picks the one flag of the highest priority pending cause
  function automatic logic [7:0] pick_cause(input logic pin, input logic sup,
                                            input logic clk_l, input logic cmp,
                                            input logic wdg, input logic fl,
                                            input logic rtc, input logic sw);
    logic [7:0] f;
    f = 8'h00;
    if (pin) begin
      f[RCR_PIN_BIT] = 1'b1;
    end else if (sup) begin
      f[RCR_POWER_BIT] = 1'b1;
    end else if (clk_l) begin
      f[RCR_CLOCK_BIT] = 1'b1;
    end else if (cmp) begin
      f[RCR_CMP_BIT] = 1'b1;
    end else if (wdg) begin
      f[RCR_WDOG_BIT] = 1'b1;
    end else if (fl) begin
      f[RCR_FLASH_BIT] = 1'b1;
    end else if (rtc) begin
      f[RCR_RTC_BIT] = 1'b1;
    end else if (sw) begin
      f[RCR_SOFT_BIT] = 1'b1;
    end
    return f;
  endfunction

  // Two-flop synchroniser for every asynchronous pin
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1    <= SYNC_RST_VALUE;
      sync2    <= SYNC_RST_VALUE;
      act_prev <= 1'b0;
    end else begin
      sync1    <= {CLK_ACTIVITY, VBAT_ABOVE_WARN, VDD_ABOVE_WARN, VDD_ABOVE_RST,
                   RTC_OSC_FAIL, RTC_ALARM, CMP_OUT, RST_PIN_I};
      sync2    <= sync1;
      act_prev <= sync2[PIN_CLK_ACT];
    end
  end

  // Reset requests from each source
  always_comb begin
    running    = (state == ST_RUN);
    wr_smc     = running && SFR_WR && (SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR);
    wr_rcr     = running && SFR_WR && (SFR_ADDR == RESET_CAUSE_REGISTER_ADDR);
    pin_req    = !sync2[PIN_RST];
    supply_req = monitor_on && supply_sel && !sync2[PIN_VDD_RST] && !LOW_POWER;
    clock_req  = clock_loss_en && !LOW_POWER && clk_tmr.expired;
    cmp_req    = cmp_en && !sync2[PIN_CMP] && (!LOW_POWER || CMP_WAKE_EN);
    wdog_req   = wdog_en && !LOW_POWER && wdg_tmr.expired;
    flash_req  = FLASH_FAULT;
    rtc_req    = rtc_en && (sync2[PIN_ALARM] || sync2[PIN_OSC_FAIL]);
    soft_req   = wr_rcr && SFR_WDATA[RCR_SOFT_BIT];
    req_cause  = pick_cause(pin_req, supply_req, clock_req, cmp_req, wdog_req,
                            flash_req, rtc_req, soft_req);
  end

  // Clock-loss timer: restarted by every clock activity edge
  always_comb begin
    clk_tmr.run  = running && clock_loss_en && !LOW_POWER;
    clk_tmr.kick = sync2[PIN_CLK_ACT] ^ act_prev;
    clk_tmr.tick = 1'b1;
  end

  // Watchdog timer: ticks at clock/12, restarted by service
  always_comb begin
    next_div_cnt = (div_cnt == DIV_LAST) ? '0 : div_cnt + DV_W'(1);
    wdg_tmr.run  = running && wdog_en && !LOW_POWER;
    wdg_tmr.kick = WDOG_SERVICE;
    wdg_tmr.tick = (div_cnt == DIV_LAST);
  end

  rss_timer #(.LIMIT(CLK_LOSS_CYCLES)) u_clock_loss (
    .CLK   (CLK),
    .RST_N (RST_N),
    .t     (clk_tmr)
  );

  rss_timer #(.LIMIT(WDOG_TICKS)) u_watchdog (
    .CLK   (CLK),
    .RST_N (RST_N),
    .t     (wdg_tmr)
  );

  // Reset sequencing: record one cause; own pin drive ends before the pin is watched
  always_comb begin
    next_state     = state;
    next_hold_cnt  = hold_cnt;
    next_cause     = cause;
    next_drive_pin = drive_pin;
    unique case (state)
      ST_RUN: begin
        if (req_cause != 8'h00) begin
          next_state     = ST_HOLD;
          next_hold_cnt  = '0;
          next_cause     = req_cause;
          next_drive_pin = req_cause[RCR_POWER_BIT];
        end
      end
      ST_HOLD: begin
        if ((pin_req && !drive_pin) || (drive_pin && !sync2[PIN_VDD_RST])) begin
          next_hold_cnt = '0;
        end else if (hold_cnt != HOLD_LAST) begin
          next_hold_cnt = hold_cnt + HC_W'(1);
        end else begin
          next_hold_cnt  = '0;
          next_drive_pin = 1'b0;
          next_state     = drive_pin ? ST_HOLD : ST_RUN;
        end
      end
    endcase
  end

  // Software settings and their reset behaviour
  always_comb begin
    next_monitor_on    = monitor_on;
    next_supply_sel    = supply_sel;
    next_core_irq_en   = core_irq_en;
    next_batt_irq_en   = batt_irq_en;
    next_clock_loss_en = clock_loss_en;
    next_cmp_en        = cmp_en;
    next_rtc_en        = rtc_en;
    next_wdog_en       = wdog_en;
    if (state == ST_HOLD) begin
      next_wdog_en     = 1'b1;
      next_core_irq_en = SMC_CORE_IRQ_EN_RST;
      next_batt_irq_en = SMC_BATT_IRQ_EN_RST;
      if (cause[RCR_POWER_BIT]) begin
        next_monitor_on = SMC_MONITOR_ON_RST;
        next_supply_sel = 1'b1;
      end
    end else begin
      if (wr_smc) begin
        next_monitor_on  = SFR_WDATA[SMC_MONITOR_ON_BIT];
        next_core_irq_en = SFR_WDATA[SMC_CORE_IRQ_EN_BIT];
        next_batt_irq_en = SFR_WDATA[SMC_BATT_IRQ_EN_BIT];
      end
      if (wr_rcr) begin
        next_rtc_en        = SFR_WDATA[RCR_RTC_BIT];
        next_cmp_en        = SFR_WDATA[RCR_CMP_BIT];
        next_clock_loss_en = SFR_WDATA[RCR_CLOCK_BIT];
        next_supply_sel    = SFR_WDATA[RCR_POWER_BIT];
      end
      if (WDOG_DISABLE) begin
        next_wdog_en = 1'b0;
      end
    end
  end

  // Read data mux, captured on a read strobe
  always_comb begin
    next_rdata = rdata;
    if (SFR_RD) begin
      next_rdata = 8'h00;
      if (SFR_ADDR == SUPPLY_MONITOR_CONTROL_ADDR) begin
        next_rdata[SMC_MONITOR_ON_BIT]  = monitor_on;
        next_rdata[SMC_ABOVE_RST_BIT]   = sync2[PIN_VDD_RST];
        next_rdata[SMC_ABOVE_WARN_BIT]  = sync2[PIN_VDD_WARN];
        next_rdata[SMC_BATT_WARN_BIT]   = sync2[PIN_VBAT];
        next_rdata[SMC_CORE_IRQ_EN_BIT] = core_irq_en;
        next_rdata[SMC_BATT_IRQ_EN_BIT] = batt_irq_en;
      end else if (SFR_ADDR == RESET_CAUSE_REGISTER_ADDR) begin
        next_rdata = cause;
      end
    end
  end

  // State and settings registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state         <= ST_HOLD;
      hold_cnt      <= '0;
      cause         <= CAUSE_POWER_ON;
      drive_pin     <= 1'b1;
      monitor_on    <= SMC_MONITOR_ON_RST;
      supply_sel    <= 1'b1;
      core_irq_en   <= SMC_CORE_IRQ_EN_RST;
      batt_irq_en   <= SMC_BATT_IRQ_EN_RST;
      clock_loss_en <= 1'b0;
      cmp_en        <= 1'b0;
      rtc_en        <= 1'b0;
      wdog_en       <= 1'b1;
      div_cnt       <= '0;
    end else begin
      state         <= next_state;
      hold_cnt      <= next_hold_cnt;
      cause         <= next_cause;
      drive_pin     <= next_drive_pin;
      monitor_on    <= next_monitor_on;
      supply_sel    <= next_supply_sel;
      core_irq_en   <= next_core_irq_en;
      batt_irq_en   <= next_batt_irq_en;
      clock_loss_en <= next_clock_loss_en;
      cmp_en        <= next_cmp_en;
      rtc_en        <= next_rtc_en;
      wdog_en       <= next_wdog_en;
      div_cnt       <= next_div_cnt;
    end
  end

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata      <= 8'h00;
      SYS_RST_N  <= 1'b0;
      RST_PIN_O  <= 1'b0;
      RST_PIN_OE <= 1'b1;
      core_irq   <= 1'b0;
      batt_irq   <= 1'b0;
    end else begin
      rdata      <= next_rdata;
      SYS_RST_N  <= (next_state == ST_RUN);
      RST_PIN_O  <= 1'b0;
      RST_PIN_OE <= next_drive_pin;
      core_irq   <= core_irq_en && !sync2[PIN_VDD_WARN];
      batt_irq   <= batt_irq_en && !sync2[PIN_VBAT];
    end
  end

  assign SFR_RDATA     = rdata;
  assign CORE_WARN_IRQ = core_irq;
  assign BATT_WARN_IRQ = batt_irq;

endmodule

// ---- dv/rss_sequencer_assertions.sv ----
`timescale 1ns/1ps
module rss_sequencer_assertions
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST_N,
  // Register bus
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  // Pin and outputs
  input wire logic       RST_PIN_I,
  input wire logic       RST_PIN_O,
  input wire logic       RST_PIN_OE,
  input wire logic       VDD_ABOVE_WARN,
  input wire logic       VBAT_ABOVE_WARN,
  input wire logic       SYS_RST_N,
  input wire logic       CORE_WARN_IRQ,
  input wire logic       BATT_WARN_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Pin is only pulled low, and only while in reset
  property p_oe_in_rst; SYS_RST_N |-> !RST_PIN_OE; endproperty
  a_oe_in_rst: assert property (p_oe_in_rst) else $error("pin pulled in run");
  property p_drive_low; RST_PIN_OE |-> !RST_PIN_O; endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin driven high");
  // Soft write resets next cycle without the pin
  property p_soft;
    SYS_RST_N && RST_PIN_I && SFR_WR && SFR_ADDR == RESET_CAUSE_REGISTER_ADDR && SFR_WDATA[4]
      |=> !SYS_RST_N && !RST_PIN_OE;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset wrong");
  // Register reads
  property p_smc_low; SFR_RD && SFR_ADDR == 8'hff |=> SFR_RDATA[1:0] == 2'b00; endproperty
  a_smc_low: assert property (p_smc_low) else $error("unused bits set");
  property p_onehot; SFR_RD && SFR_ADDR == 8'hef |=> $onehot0(SFR_RDATA); endproperty
  a_onehot: assert property (p_onehot) else $error("several cause flags");
  // Pin reset and its hold
  property p_pin_rst; !RST_PIN_I [*4] |-> !SYS_RST_N; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed");
  property p_hold; $rose(SYS_RST_N) |-> !$past(SYS_RST_N) && !$past(SYS_RST_N, 4); endproperty
  a_hold: assert property (p_hold) else $error("reset too short");
  // Warning interrupts quiet while levels are above
  property p_core_irq; VDD_ABOVE_WARN [*4] |-> !CORE_WARN_IRQ; endproperty
  a_core_irq: assert property (p_core_irq) else $error("core irq spurious");
  property p_batt_irq; VBAT_ABOVE_WARN [*4] |-> !BATT_WARN_IRQ; endproperty
  a_batt_irq: assert property (p_batt_irq) else $error("batt irq spurious");
endmodule

bind rss_sequencer rss_sequencer_assertions i_rss_sequencer_assertions (
  .CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
  .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .RST_PIN_I(RST_PIN_I),
  .RST_PIN_O(RST_PIN_O), .RST_PIN_OE(RST_PIN_OE), .VDD_ABOVE_WARN(VDD_ABOVE_WARN),
  .VBAT_ABOVE_WARN(VBAT_ABOVE_WARN), .SYS_RST_N(SYS_RST_N),
  .CORE_WARN_IRQ(CORE_WARN_IRQ), .BATT_WARN_IRQ(BATT_WARN_IRQ));

// ---- dv/rss_far_side.sv ----
`timescale 1ns/1ps
module rss_far_side (
  // Clock
  input  wire logic clk,
  // Device pin drive
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Conditions set by the bench
  input  wire logic pull_low,
  input  wire logic clk_stop,
  input  wire logic cmp_low,
  input  wire logic vdd_low,
  input  wire logic warn_low,
  input  wire logic vbat_low,
  // Levels seen by the device
  output logic      pin_i,
  output logic      activity,
  output logic      cmp_out,
  output logic      vdd_above_rst,
  output logic      vdd_above_warn,
  output logic      vbat_above_warn
);
  // Open-drain line with pull-up
  assign pin_i = (pull_low || (pin_oe && !pin_o)) ? 1'b0 : 1'b1;
  // Settled comparator, low when plus is below minus
  assign cmp_out = !cmp_low;
  // Supply levels
  assign vdd_above_rst = !vdd_low;
  assign vdd_above_warn = !warn_low;
  assign vbat_above_warn = !vbat_low;
  // Clock source activity, stands still when stopped
  initial activity = 1'b0;
  always @(posedge clk) begin
    if (!clk_stop) activity <= !activity;
  end
endmodule

// ---- dv/rss_sequencer_tb.sv ----
`timescale 1ns/1ps
module rss_sequencer_tb;
  import rss_pkg::*;
  logic        clk, rst_n, sfr_wr, sfr_rd, pin_i, pin_o, pin_oe, cmp_out, rtc_alarm;
  logic        rtc_osc_fail, vdd_rst, vdd_warn, vbat_warn, clk_act, low_power, cmp_wake;
  logic        flash_fault, wdog_service, wdog_disable, sys_rst_n, core_irq, batt_irq;
  logic        pull_low, clk_stop, cmp_low, vdd_low, warn_low, vbat_low, oe_seen;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd;
  logic [31:0] seed;
  int          failures, checked, n;

  rss_sequencer #(.WDOG_TICKS(4)) i_rss_sequencer (
    .CLK(clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr),
    .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .RST_PIN_I(pin_i), .RST_PIN_O(pin_o),
    .RST_PIN_OE(pin_oe), .CMP_OUT(cmp_out), .RTC_ALARM(rtc_alarm), .RTC_OSC_FAIL(rtc_osc_fail),
    .VDD_ABOVE_RST(vdd_rst), .VDD_ABOVE_WARN(vdd_warn), .VBAT_ABOVE_WARN(vbat_warn),
    .CLK_ACTIVITY(clk_act), .LOW_POWER(low_power), .CMP_WAKE_EN(cmp_wake),
    .FLASH_FAULT(flash_fault), .WDOG_SERVICE(wdog_service), .WDOG_DISABLE(wdog_disable),
    .SYS_RST_N(sys_rst_n), .CORE_WARN_IRQ(core_irq), .BATT_WARN_IRQ(batt_irq));
  rss_far_side i_rss_far_side (
    .clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pull_low(pull_low), .clk_stop(clk_stop),
    .cmp_low(cmp_low), .vdd_low(vdd_low), .warn_low(warn_low), .vbat_low(vbat_low),
    .pin_i(pin_i), .activity(clk_act), .cmp_out(cmp_out), .vdd_above_rst(vdd_rst),
    .vdd_above_warn(vdd_warn), .vbat_above_warn(vbat_warn));

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    results();
  end

  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] smc_exp(input logic [7:0] w);
    return {w[7], !vdd_low, !warn_low, !vbat_low, w[3:2], 2'b00};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
    rd = sfr_rdata;
  endtask
  task automatic quiet(input int k);
    logic low;
    low = 1'b0;
    repeat (k) begin
      @(negedge clk);
      low |= !sys_rst_n;
    end
    chk("no reset", 8'(low), 8'h00);
  endtask
  // Await a reset, withdraw faults, await release, read the cause
  task automatic wait_rst(input int lim, input logic dis, input logic [7:0] m,
                          input logic [7:0] cause, input logic oe);
    n = 0;
    oe_seen = 1'b0;
    while (sys_rst_n !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    {pull_low, clk_stop, cmp_low, vdd_low, rtc_alarm, rtc_osc_fail, flash_fault} = '0;
    low_power = 1'b0;
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 200) begin
      oe_seen |= pin_oe;
      @(negedge clk);
      n++;
    end
    if (dis) begin
      wdog_disable = 1'b1;
      @(negedge clk);
      wdog_disable = 1'b0;
    end
    rdr(RESET_CAUSE_REGISTER_ADDR);
    chk("cause", rd & m, cause & m);
    chk("pin drive", 8'(oe_seen), 8'(oe));
  endtask
  task automatic results;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, sfr_wr, sfr_rd, rtc_alarm, rtc_osc_fail, low_power, cmp_wake, flash_fault} = '0;
    {wdog_service, wdog_disable, pull_low, clk_stop, cmp_low, vdd_low, warn_low, vbat_low} = '0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    seed = 32'hb1ca3321;
    failures = 0;
    checked = 0;
    repeat (7) @(negedge clk);
    rst_n = 1'b1;
    wait_rst(50, 1'b1, 8'h02, 8'h02, 1'b1);
    rdr(SUPPLY_MONITOR_CONTROL_ADDR);
    chk("smc", rd, smc_exp(8'h88));
    warn_low = 1'b1;
    vbat_low = 1'b1;
    wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h84);
    @(negedge clk);
    chk("core irq", 8'(core_irq), 8'h00);
    chk("batt irq", 8'(batt_irq), 8'h01);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      {warn_low, vbat_low} = seed[9:8];
      wr(SUPPLY_MONITOR_CONTROL_ADDR, seed[7:0] | 8'h80);
      rdr(SUPPLY_MONITOR_CONTROL_ADDR);
      chk("smc", rd, smc_exp(seed[7:0] | 8'h80));
      chk("core irq", 8'(core_irq), 8'(seed[3] & warn_low));
      chk("batt irq", 8'(batt_irq), 8'(seed[2] & vbat_low));
      rdr({seed[15:13], 2'b00, seed[10:8]});
      chk("unmapped", rd, 8'h00);
    end
    {warn_low, vbat_low} = 2'b00;
    wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h88);
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h12);
    wait_rst(20, 1'b1, 8'hff, 8'h10, 1'b0);
    low_power = 1'b1;
    pull_low = 1'b1;
    wait_rst(20, 1'b1, 8'hff, 8'h01, 1'b0);
    flash_fault = 1'b1;
    wait_rst(20, 1'b1, 8'hff, 8'h40, 1'b0);
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h82);
    rtc_alarm = 1'b1;
    wait_rst(20, 1'b1, 8'hff, 8'h80, 1'b0);
    low_power = 1'b1;
    rtc_osc_fail = 1'b1;
    wait_rst(20, 1'b1, 8'hff, 8'h80, 1'b0);
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h22);
    low_power = 1'b1;
    cmp_low = 1'b1;
    quiet(40);
    cmp_wake = 1'b1;
    wait_rst(20, 1'b1, 8'hff, 8'h20, 1'b0);
    cmp_wake = 1'b0;
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h02);
    cmp_low = 1'b1;
    quiet(20);
    cmp_low = 1'b0;
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h06);
    low_power = 1'b1;
    clk_stop = 1'b1;
    quiet(2100);
    low_power = 1'b0;
    wait_rst(2100, 1'b1, 8'hff, 8'h04, 1'b0);
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h02);
    clk_stop = 1'b1;
    quiet(2100);
    clk_stop = 1'b0;
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h12);
    wait_rst(20, 1'b0, 8'hff, 8'h10, 1'b0);
    n = 0;
    while (sys_rst_n === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("wdog time", 8'(n >= 30 && n <= 64), 8'h01);
    wait_rst(20, 1'b0, 8'hff, 8'h08, 1'b0);
    low_power = 1'b1;
    quiet(150);
    low_power = 1'b0;
    wait_rst(100, 1'b0, 8'hff, 8'h08, 1'b0);
    repeat (8) begin
      quiet(20);
      wdog_service = 1'b1;
      @(negedge clk);
      wdog_service = 1'b0;
    end
    wdog_disable = 1'b1;
    wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h08);
    wdog_disable = 1'b0;
    vdd_low = 1'b1;
    quiet(30);
    rdr(SUPPLY_MONITOR_CONTROL_ADDR);
    chk("smc", rd, smc_exp(8'h08));
    wr(SUPPLY_MONITOR_CONTROL_ADDR, 8'h80);
    wait_rst(20, 1'b1, 8'h02, 8'h02, 1'b1);
    rdr(SUPPLY_MONITOR_CONTROL_ADDR);
    chk("smc", rd, smc_exp(8'h88));
    wr(RESET_CAUSE_REGISTER_ADDR, 8'h00);
    vdd_low = 1'b1;
    quiet(30);
    results();
  end
endmodule
